// ===== verilog/scl_clock_flow.sv
// Two-wire serial host port: SCL generation as master, input filters,
// and the host request handshake. Assumes open-drain pins resolved outside.
`timescale 1ns/10ps
// Notes on behaviour
// - cycle = Tc * 2 * (modulus + 1) * (7 * not bypass + 1).
// - bypass low inserts divide by eight; high skips it.
// - all eight modulus bits give divide ratios one to 256.
// - programmed cycle spans two to 4096 core periods.
// - real SCL cycle adds sync, filter delay and rise time.
// - filters reject spikes up to 50 ns narrow, 100 ns wide.
// - slave drops request soon after the first SCL edge of either polarity.
// - slave keeps request low a minimum after last SCL edge.
// - master waits for request input before first SCL edge.
module scl_clock_flow
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Configuration
  input  wire logic [MOD_WIDTH-1:0] clock_divider_modulus,
  input  wire logic                 prescaler_bypass,
  input  wire logic [1:0]           filter_sel,
  input  wire logic                 master_mode,
  input  wire logic                 request_wait_en,
  // Transfer control
  input  wire logic                 xfer_start,
  input  wire logic [4:0]           xfer_edges,
  input  wire logic                 slave_ready,
  // Pins
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      scl_out,
  output logic                      scl_oe_n,
  input  wire logic                 host_request_line_in,
  output logic                      host_request_line_out,
  // Status
  output logic                      scl_filtered,
  output logic                      sda_filtered,
  output logic                      xfer_busy
);
  // ==========================================================
  // Synchronisers and filters
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] req_sync_reg;
  logic       scl_f;
  logic       sda_f;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      req_sync_reg <= 2'h0;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      req_sync_reg <= {req_sync_reg[0], host_request_line_in};
    end
  end

  spike_filter u_scl_filter (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .filter_sel (filter_sel),
    .line_in    (scl_sync_reg[1]),
    .line_out   (scl_f)
  );

  spike_filter u_sda_filter (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .filter_sel (filter_sel),
    .line_in    (sda_sync_reg[1]),
    .line_out   (sda_f)
  );

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      scl_filtered <= 1'b1;
      sda_filtered <= 1'b1;
    end
    else
    begin
      scl_filtered <= scl_f;
      sda_filtered <= sda_f;
    end
  end

  // ==========================================================
  // Half-cycle divider
  // Each SCL half lasts (modulus+1)*(8 or 1) core periods; the whole
  // cycle is twice that.
  logic [CNT_WIDTH-1:0] half_len;
  logic [CNT_WIDTH-1:0] div_reg;
  logic                 half_tick;

  always_comb
  begin
    if (prescaler_bypass)
      half_len = CNT_WIDTH'({4'h0, clock_divider_modulus} + 12'h1);
    else
      half_len = CNT_WIDTH'(({4'h0, clock_divider_modulus} + 12'h1) << 3);
  end

  assign half_tick = (div_reg >= half_len - 12'h1);

  // ==========================================================
  // Master state machine
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_LOW  = 4'b0100,
    ST_HIGH = 4'b1000
  } mstate_t;

  mstate_t    state_reg;
  logic [4:0] edges_reg;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      div_reg   <= '0;
      edges_reg <= 5'h0;
      scl_out   <= SCL_RESET;
      scl_oe_n  <= 1'b1;
      xfer_busy <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          div_reg  <= '0;
          scl_oe_n <= 1'b1;
          scl_out  <= 1'b1;
          if (xfer_start && master_mode && xfer_edges != 5'h0)
          begin
            edges_reg <= xfer_edges;
            xfer_busy <= 1'b1;
            state_reg <= ST_WAIT;
          end
          else
            xfer_busy <= 1'b0;
        end
        ST_WAIT:
        begin
          // Hold off the first edge until the partner asks; half a cycle
          // elapses after the request before SCL falls
          if (!request_wait_en || req_sync_reg[1])
          begin
            if (half_tick)
            begin
              div_reg   <= '0;
              scl_out   <= 1'b0;
              scl_oe_n  <= 1'b0;
              state_reg <= ST_LOW;
            end
            else
              div_reg <= div_reg + 12'h1;
          end
          else
            div_reg <= '0;
        end
        ST_LOW:
        begin
          if (half_tick)
          begin
            div_reg   <= '0;
            scl_oe_n  <= 1'b1;
            state_reg <= ST_HIGH;
          end
          else
            div_reg <= div_reg + 12'h1;
        end
        ST_HIGH:
        begin
          // Count only once the line is seen high: stretching and the
          // filter delay lengthen the real cycle
          if (!scl_f)
            div_reg <= '0;
          else if (half_tick)
          begin
            div_reg <= '0;
            if (edges_reg == 5'h1)
              state_reg <= ST_IDLE;
            else if (request_wait_en && !req_sync_reg[1])
            begin
              edges_reg <= edges_reg - 5'h1;
              state_reg <= ST_WAIT;
            end
            else
            begin
              edges_reg <= edges_reg - 5'h1;
              scl_out   <= 1'b0;
              scl_oe_n  <= 1'b0;
              state_reg <= ST_LOW;
            end
          end
          else
            div_reg <= div_reg + 12'h1;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Slave request output
  logic       scl_f_d_reg;
  logic [5:0] hold_reg;
  logic [5:0] hold_len;

  always_comb
  begin
    case (filter_sel)
      FILT_NARROW: hold_len = 6'(REQ_HOLD_NAR_CYC);
      FILT_WIDE:   hold_len = 6'(REQ_HOLD_WIDE_CYC);
      default:     hold_len = 6'(REQ_HOLD_BYP_CYC);
    endcase
  end

  // Any SCL edge drops the request and restarts the quiet-time count;
  // the filters already add the delay the partner must allow for
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      scl_f_d_reg           <= 1'b1;
      hold_reg              <= 6'h0;
      host_request_line_out <= REQ_RESET;
    end
    else
    begin
      scl_f_d_reg <= scl_f;
      if (master_mode)
      begin
        host_request_line_out <= 1'b0;
        hold_reg              <= 6'h0;
      end
      else if (scl_f != scl_f_d_reg)
      begin
        host_request_line_out <= 1'b0;
        hold_reg              <= 6'h0;
      end
      else if (hold_reg < hold_len)
        hold_reg <= hold_reg + 6'h1;
      else
        host_request_line_out <= slave_ready;
    end
  end
endmodule // scl_clock_flow

// ===== verilog/scl_pkg.sv
// Constants for the two-wire serial host port clock and flow block.
// Assumes a 250 MHz core clock (ref_clk).
package scl_pkg;
  localparam int          CLK_PERIOD_PS      = 4000;
  localparam int          MOD_WIDTH          = 8;
  localparam int          PRESCALE_RATIO     = 8;
  localparam int          HALF_CYCLES_BASE   = 1;
  // Filter selections
  localparam logic [1:0]  FILT_BYPASS        = 2'h0;
  localparam logic [1:0]  FILT_NARROW        = 2'h1;
  localparam logic [1:0]  FILT_WIDE          = 2'h2;
  // Spike widths rejected by the filters
  localparam int          NARROW_SPIKE_NS    = 50;
  localparam int          WIDE_SPIKE_NS      = 100;
  localparam int          NARROW_SPIKE_CYC   = (NARROW_SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          WIDE_SPIKE_CYC     = (WIDE_SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Least time the request output stays deasserted after the last edge
  localparam int          REQ_HOLD_BYP_NS    = 50;
  localparam int          REQ_HOLD_NAR_NS    = 100;
  localparam int          REQ_HOLD_WIDE_NS   = 155;
  localparam int          REQ_HOLD_BYP_CYC   = (REQ_HOLD_BYP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          REQ_HOLD_NAR_CYC   = (REQ_HOLD_NAR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          REQ_HOLD_WIDE_CYC  = (REQ_HOLD_WIDE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CNT_WIDTH          = 12;
  // Reset values
  localparam logic        SCL_RESET          = 1'b1;
  localparam logic        REQ_RESET          = 1'b0;
endpackage

// ===== verilog/spike_filter.sv
// Glitch filter for one synchronised two-wire line.
// Assumes the input is already in the ref_clk domain.
`timescale 1ns/10ps
module spike_filter
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Setting and line
  input  wire logic [1:0] filter_sel,
  input  wire logic       line_in,
  output logic            line_out
);
  logic [4:0] run_reg;
  logic [4:0] limit;

  always_comb
  begin
    case (filter_sel)
      FILT_NARROW: limit = 5'(NARROW_SPIKE_CYC);
      FILT_WIDE:   limit = 5'(WIDE_SPIKE_CYC);
      default:     limit = 5'h0;
    endcase
  end

  // A change must persist longer than the limit before it is passed on
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      run_reg  <= 5'h0;
      line_out <= 1'b1;
    end
    else if (line_in == line_out)
      run_reg <= 5'h0;
    else if (run_reg >= limit)
    begin
      line_out <= line_in;
      run_reg  <= 5'h0;
    end
    else
      run_reg <= run_reg + 5'h1;
  end
endmodule // spike_filter

// ===== tb/scl_monitor.sv
// Port assertions for the SCL clock and flow block.
// Assumes configuration is held steady while a transfer is busy.
`timescale 1ns/10ps
module scl_monitor
  import scl_pkg::*;
(
  // Clock, reset, configuration
  input wire logic                 ref_clk,
  input wire logic                 reset,
  input wire logic [MOD_WIDTH-1:0] clock_divider_modulus,
  input wire logic                 prescaler_bypass,
  input wire logic [1:0]           filter_sel,
  input wire logic                 master_mode,
  input wire logic                 request_wait_en,
  input wire logic                 xfer_start,
  input wire logic [4:0]           xfer_edges,
  input wire logic                 slave_ready,
  // Observed outputs
  input wire logic                 scl_oe_n,
  input wire logic                 host_request_line_in,
  input wire logic                 host_request_line_out,
  input wire logic                 scl_filtered,
  input wire logic                 xfer_busy
);
  logic [11:0] half_len, low_cnt, high_cnt;
  logic [7:0]  quiet_cnt, hold_len;
  logic        filt_q;
  assign half_len = (12'(clock_divider_modulus) + 12'h001) * (prescaler_bypass ? 12'h001 : 12'h008);
  assign hold_len = (filter_sel == FILT_NARROW) ? 8'(REQ_HOLD_NAR_CYC)
                  : (filter_sel == FILT_WIDE) ? 8'(REQ_HOLD_WIDE_CYC) : 8'(REQ_HOLD_BYP_CYC);
  // High and quiet counts saturate, low count wraps; quiet starts full so reset itself is not an edge
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      low_cnt   <= 12'h000;
      high_cnt  <= 12'h000;
      quiet_cnt <= 8'hff;
      filt_q    <= 1'b1;
    end
    else
    begin
      low_cnt   <= scl_oe_n ? 12'h000 : low_cnt + 12'h001;
      high_cnt  <= !scl_oe_n ? 12'h000 : (high_cnt == 12'hfff) ? high_cnt : high_cnt + 12'h001;
      filt_q    <= scl_filtered;
      quiet_cnt <= (scl_filtered != filt_q) ? 8'h00 : (quiet_cnt == 8'hff) ? quiet_cnt : quiet_cnt + 8'h01;
    end
  default clocking mon_cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_low_phase_len: assert property ($rose(scl_oe_n) |-> low_cnt == half_len)
    else $error("SCL low phase length wrong");
  a_high_phase_min: assert property ($fell(scl_oe_n) |-> high_cnt >= half_len)
    else $error("SCL high phase too short");
  a_start_gives_busy: assert property (master_mode && !xfer_busy && xfer_start && xfer_edges != 5'h00 |=> xfer_busy)
    else $error("Transfer start not taken");
  a_wait_for_req: assert property ($rose(xfer_busy) ##0 (request_wait_en && !host_request_line_in)[*4] |-> scl_oe_n)
    else $error("SCL driven before request");
  a_idle_no_drive: assert property (!xfer_busy || !master_mode |-> scl_oe_n)
    else $error("SCL driven outside transfer");
  a_req_drop_edge: assert property (!master_mode && $changed(scl_filtered) |=> !host_request_line_out)
    else $error("Request not dropped after SCL edge");
  a_req_hold_min: assert property (!master_mode && $rose(host_request_line_out) |-> quiet_cnt >= hold_len)
    else $error("Request raised too soon");
  a_req_not_ready: assert property (!master_mode && !slave_ready [*2] |-> !host_request_line_out)
    else $error("Request raised while not ready");
endmodule // scl_monitor
bind scl_clock_flow scl_monitor scl_monitor_inst (
  .ref_clk               (ref_clk),
  .reset                 (reset),
  .clock_divider_modulus (clock_divider_modulus),
  .prescaler_bypass      (prescaler_bypass),
  .filter_sel            (filter_sel),
  .master_mode           (master_mode),
  .request_wait_en       (request_wait_en),
  .xfer_start            (xfer_start),
  .xfer_edges            (xfer_edges),
  .slave_ready           (slave_ready),
  .scl_oe_n              (scl_oe_n),
  .host_request_line_in  (host_request_line_in),
  .host_request_line_out (host_request_line_out),
  .scl_filtered          (scl_filtered),
  .xfer_busy             (xfer_busy)
);

// ===== tb/scl_far_end.sv
// Far-end model: open-drain SCL with pull-up and the request line.
// Assumes the bench gives the edge count of each transfer.
`timescale 1ns/10ps
module scl_far_end
(
  // Pins and control
  input  wire logic       ref_clk,
  input  wire logic       scl_out,
  input  wire logic       scl_oe_n,
  input  wire logic       pull_low,
  input  wire logic       req_en,
  input  wire logic [4:0] edges,
  output logic            scl_wire,
  output logic            req
);
  logic       scl_q = 1'b1;
  logic [4:0] falls = 5'h00;
  assign scl_wire = !((!scl_oe_n && !scl_out) || pull_low);
  // Request drops on the last falling edge, before the final rising one
  always @(posedge ref_clk)
  begin
    scl_q <= scl_wire;
    if (!req_en) falls <= 5'h00;
    else if (scl_q && !scl_wire) falls <= falls + 5'h01;
    req <= req_en && (falls < edges) && !(scl_q && !scl_wire && falls + 5'h01 >= edges);
  end
endmodule // scl_far_end

// ===== tb/tb_scl_clock_flow.sv
// Self-checking bench for the clock and flow block.
// Assumes scl_far_end stands on the SCL wire and request line.
`timescale 1ns/10ps
module tb_scl_clock_flow
  import scl_pkg::*;
;
  logic ref_clk = 0, reset = 1, bypass = 1, master = 1, wait_en = 1, start = 0, ready = 0, pull = 0, req_en = 0;
  logic [7:0] modv = 8'h00;
  logic [4:0] edges = 5'h00;
  logic [1:0] fsel = FILT_BYPASS;
  logic       scl_w, req, oe_n, scl_o, req_out, sf, sdf, busy;
  logic       sda = 1;
  integer     seed = 6220, err_total = 0, n_compared = 0, i;
  scl_clock_flow scl_clock_flow_inst (.ref_clk(ref_clk), .reset(reset), .clock_divider_modulus(modv),
    .prescaler_bypass(bypass), .filter_sel(fsel), .master_mode(master), .request_wait_en(wait_en),
    .xfer_start(start), .xfer_edges(edges), .slave_ready(ready), .scl_in(scl_w), .sda_in(sda),
    .scl_out(scl_o), .scl_oe_n(oe_n), .host_request_line_in(req), .host_request_line_out(req_out),
    .scl_filtered(sf), .sda_filtered(sdf), .xfer_busy(busy));
  scl_far_end scl_far_end_inst (.ref_clk(ref_clk), .scl_out(scl_o), .scl_oe_n(oe_n), .pull_low(pull),
    .req_en(req_en), .edges(edges), .scl_wire(scl_w), .req(req));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin err_total++; $display("ERROR %0t seen %0d expected %0d", $time, seen, exp); end
  endtask
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Master transfer; model queues one expected low length per pulse
  task automatic xfer(input logic [7:0] m, input logic b, input logic [4:0] e, input int waitc);
    int q[$];
    int len, lows, t;
    len = 0;
    lows = 0;
    for (t = 0; t < e; t++) q.push_back((m + 1) * (b ? 1 : 8));
    step(1);
    modv = m; bypass = b; edges = e; master = 1; req_en = (waitc == 0); start = 1;
    step(1);
    start = 0;
    step(1);
    start = 1;
    step(1);
    start = 0;
    for (t = 0; t < 30000 && (t < 4 + waitc || busy !== 1'b0); t++)
    begin
      if (t == waitc && waitc > 0) chk(lows, wait_en ? 0 : e);
      if (t == waitc) req_en = 1;
      if (oe_n === 1'b0)
      begin
        len++;
        chk(scl_o, 0);
      end
      else if (len > 0)
      begin
        chk(len, (q.size() > 0) ? q.pop_front() : 0);
        lows++;
        len = 0;
      end
      step(1);
    end
    chk(lows, e);
    chk(busy, 0);
    req_en = 0;
  endtask
  // Slave: spike on SCL, then watch the request line drop and return
  task automatic spike(input logic [1:0] f, input int w, input logic pass);
    logic drop, sdrop;
    drop = 0;
    sdrop = 0;
    master = 0; fsel = f; ready = 1;
    step(80);
    chk(req_out, 1);
    pull = 1;
    sda = 0;
    for (i = 0; i < w + 120; i++)
    begin
      if (i == w)
      begin
        pull = 0;
        sda = 1;
      end
      drop = drop | (req_out === 1'b0);
      sdrop = sdrop | (sdf === 1'b0);
      step(1);
    end
    chk(drop, pass);
    chk(req_out, 1);
    chk(sf, 1);
    chk(sdrop, pass);
    chk(sdf, 1);
  endtask
  initial
  begin
    #200000;
    err_total++;
    give_verdict;
  end
  initial
  begin
    step(2);
    reset = 0;
    xfer(8'h02, 1, 3, 20);
    xfer(8'h01, 1, 0, 0);
    wait_en = 0;
    xfer(8'h03, 1, 2, 50);
    wait_en = 1;
    xfer(8'hff, 0, 1, 0);
    for (int k = 0; k < 6; k++)
    begin
      fsel = ($random(seed) & 1) ? 2'h3 : FILT_BYPASS;
      xfer(8'(2 + ($random(seed) & 15)), 1'($random(seed)), 5'(1 + ($random(seed) & 3)), 0);
    end
    spike(FILT_NARROW, 12, 0);
    spike(FILT_NARROW, 40, 1);
    spike(FILT_WIDE, 24, 0);
    spike(FILT_WIDE, 60, 1);
    spike(FILT_BYPASS, 1, 1);
    ready = 0;
    step(4);
    chk(req_out, 0);
    give_verdict;
  end
endmodule // tb_scl_clock_flow
